// ==== core/tbdbs_pkg.sv ====
/*
 * Constants shared by the terminal bus diagnostic lamp block:
 * register offsets, field positions, reset values, timing and states.
 * Assumes a single 100 MHz system clock.
 */
package tbdbs_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS     = 10;
    localparam int FAST_HALF_NS      = 50_000_000;
    localparam int SLOW_HALF_NS      = 250_000_000;
    localparam int PAUSE_NS          = 1_000_000_000;
    localparam int RESET_BUSY_NS     = 1_000;
    localparam int FAST_HALF_CYC     = FAST_HALF_NS / CLK_PERIOD_NS;
    localparam int SLOW_HALF_CYC     = SLOW_HALF_NS / CLK_PERIOD_NS;
    localparam int PAUSE_CYC         = PAUSE_NS / CLK_PERIOD_NS;
    localparam int RESET_BUSY_CYC    = RESET_BUSY_NS / CLK_PERIOD_NS;
    localparam int TIMER_W           = 32;
    localparam logic [3:0] BURST_PULSES = 4'h8;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0]  ADDR_STATUS = 8'h00;
    localparam logic [7:0]  ADDR_CTRL   = 8'h04;
    localparam logic [7:0]  ADDR_ERR    = 8'h08;
    localparam logic [31:0] RD_UNMAPPED = 32'h0000_0000;

    // Control register fields
    localparam int CTRL_MODE_LO   = 0;
    localparam int CTRL_MODE_HI   = 1;
    localparam int CTRL_BOOT_DONE = 4;
    localparam int CTRL_SW_ERR    = 5;
    localparam int CTRL_SW_USER   = 6;
    localparam int CTRL_DEV_RESET = 8;
    localparam logic [6:0] CTRL_RESET = 7'h00;

    // Status word fields
    localparam int ST_BUS_ERR   = 0;
    localparam int ST_CFG_CHG   = 1;
    localparam int ST_LEN_MIS   = 2;
    localparam int ST_IN_INVAL  = 8;
    localparam int ST_IN_BUSY   = 9;
    localparam int ST_OUT_BUSY  = 10;
    localparam int ST_WATCHDOG  = 11;
    localparam int ST_ACYC_BUSY = 15;

    // Error register fields
    localparam int ERR_ARG_LO  = 0;
    localparam int ERR_CODE_LO = 8;
    localparam int ERR_LATCHED = 12;
    localparam int ERR_EMC     = 13;

    // ------------------------------------------------------------
    // Runtime mode and lamp colours {red, green, blue}
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        MODE_STOP   = 2'b00,
        MODE_RUN    = 2'b01,
        MODE_CONFIG = 2'b10,
        MODE_FAULT  = 2'b11
    } tbdbs_mode_e;

    localparam logic [2:0] RGB_RED    = 3'h4;
    localparam logic [2:0] RGB_GREEN  = 3'h2;
    localparam logic [2:0] RGB_BLUE   = 3'h1;
    localparam logic [2:0] RGB_YELLOW = 3'h6;

    typedef enum logic [2:0] {
        SEQ_IDLE  = 3'b000,
        SEQ_BURST = 3'b001,
        SEQ_CODE  = 3'b010,
        SEQ_PAUSE = 3'b011,
        SEQ_ARG   = 3'b100,
        SEQ_GAP   = 3'b101,
        SEQ_EMC   = 3'b110
    } tbdbs_seq_e;

endpackage : tbdbs_pkg

// ==== core/tbdbs_diag_blink.sv ====
/*
 * Diagnostic lamp logic: runtime status lamp, startup error lamp,
 * user lamp, terminal bus run and error lamps with coded blink sequence,
 * and the 16-bit terminal bus status word.
 * Assumes inputs synchronous to clk and a simple strobe register port.
 */
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps

module tbdbs_diag_blink
    import tbdbs_pkg::*;
#(
    parameter int FAST_CYC  = FAST_HALF_CYC,
    parameter int SLOW_CYC  = SLOW_HALF_CYC,
    parameter int PAUSE_LEN = PAUSE_CYC
)(
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        rst,
    // Register port
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWrData,
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    output logic      [31:0] regRdData,
    // Terminal bus error report
    input  wire logic        busErrSet,
    input  wire logic [3:0]  busErrCode,
    input  wire logic [7:0]  busErrArg,
    input  wire logic        busErrLatch,
    input  wire logic        busErrGone,
    input  wire logic        emcFault,
    // Terminal bus status inputs
    input  wire logic        fieldbusOk,
    input  wire logic        cfgChanged,
    input  wire logic        lenMismatch,
    input  wire logic        inputsInvalid,
    input  wire logic        inUpdBusy,
    input  wire logic        outUpdBusy,
    input  wire logic        watchdogHit,
    // Acyclic bus reset request toward the terminal bus
    output logic             busResetPulse,
    // Lamps
    output logic      [2:0]  runtimeStatusLampRgb,
    output logic             startupErrLamp,
    output logic             userDiagLamp,
    output logic             termRunLamp,
    output logic             termErrLamp
);

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    logic [6:0]  ctrl_reg;
    logic [TIMER_W-1:0] rstBusyCnt_reg;
    logic        errActive_reg;
    logic        errLatched_reg;
    logic [3:0]  errCode_reg;
    logic [7:0]  errArg_reg;
    logic [15:0] status_reg;

    wire         selStatus = (regAddr == ADDR_STATUS);
    wire         selCtrl   = (regAddr == ADDR_CTRL);
    wire         selErr    = (regAddr == ADDR_ERR);
    wire         ctrlWr    = regWrEn && selCtrl;
    wire         devReset  = ctrlWr && regWrData[CTRL_DEV_RESET];
    wire         rstBusy   = (rstBusyCnt_reg != '0);

    wire [31:0]  errWord   = {18'h00000, emcFault, errLatched_reg,
                              errCode_reg, errArg_reg};
    wire [31:0]  rdMux     = selStatus ? {16'h0000, status_reg} :
                             selCtrl   ? {25'h0000000, ctrl_reg} :
                             selErr    ? errWord : RD_UNMAPPED;

    always_ff @(posedge clk)
    begin
        if (rst)
            regRdData <= '0;
        else if (regRdEn)
            regRdData <= rdMux;
        else
            regRdData <= '0;
    end

    // Control register; the reset command bit is self-clearing
    always_ff @(posedge clk)
    begin
        if (rst)
            ctrl_reg <= CTRL_RESET;
        else if (ctrlWr)
            ctrl_reg <= regWrData[6:0];
    end

    // ------------------------------------------------------------
    // Device reset activity
    // ------------------------------------------------------------
    wire [TIMER_W-1:0] rstBusyNext = devReset ? TIMER_W'(RESET_BUSY_CYC) :
                                     rstBusy  ? rstBusyCnt_reg - 1'b1 :
                                                rstBusyCnt_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            rstBusyCnt_reg <= '0;
            busResetPulse  <= 1'b0;
        end
        else
        begin
            rstBusyCnt_reg <= rstBusyNext;
            busResetPulse  <= devReset;
        end
    end

    // ------------------------------------------------------------
    // Error capture; a new report wins over any clear
    // ------------------------------------------------------------
    wire errClear = devReset || (busErrGone && !errLatched_reg);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            errActive_reg  <= 1'b0;
            errLatched_reg <= 1'b0;
            errCode_reg    <= '0;
            errArg_reg     <= '0;
        end
        else if (busErrSet)
        begin
            errActive_reg  <= 1'b1;
            errLatched_reg <= busErrLatch;
            errCode_reg    <= busErrCode;
            errArg_reg     <= busErrArg;
        end
        else if (errClear)
        begin
            errActive_reg  <= 1'b0;
            errLatched_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Status word
    // ------------------------------------------------------------
    logic [15:0] statusNext;

    always_comb
    begin
        statusNext               = '0;
        statusNext[ST_BUS_ERR]   = errActive_reg;
        statusNext[ST_CFG_CHG]   = cfgChanged;
        statusNext[ST_LEN_MIS]   = lenMismatch;
        statusNext[ST_IN_INVAL]  = inputsInvalid;
        statusNext[ST_IN_BUSY]   = inUpdBusy;
        statusNext[ST_OUT_BUSY]  = outUpdBusy;
        statusNext[ST_WATCHDOG]  = watchdogHit;
        statusNext[ST_ACYC_BUSY] = rstBusy || devReset;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
            status_reg <= '0;
        else
            status_reg <= statusNext;
    end

    // ------------------------------------------------------------
    // Blink sequencer
    // ------------------------------------------------------------
    tbdbs_seq_e         seq_reg;
    tbdbs_seq_e         seq_next;
    logic [TIMER_W-1:0] timer_reg;
    logic [TIMER_W-1:0] timer_next;
    logic [7:0]         pulseCnt_reg;
    logic [7:0]         pulseCnt_next;
    logic               blinkOn_reg;
    logic               blinkOn_next;

    wire [TIMER_W-1:0]  fastHalf = TIMER_W'(FAST_CYC);
    wire [TIMER_W-1:0]  slowHalf = TIMER_W'(SLOW_CYC);
    wire [TIMER_W-1:0]  pauseLen = TIMER_W'(PAUSE_LEN);
    wire                timerEnd = (timer_reg == '0);
    wire                showErr  = errActive_reg && !emcFault;
    wire                pulseSeq = (seq_reg == SEQ_BURST) || (seq_reg == SEQ_CODE) ||
                                   (seq_reg == SEQ_ARG);
    wire [7:0]          target   = (seq_reg == SEQ_BURST) ? {4'h0, BURST_PULSES} :
                                   (seq_reg == SEQ_CODE)  ? {4'h0, errCode_reg} :
                                                            errArg_reg;
    wire [TIMER_W-1:0]  halfLen  = (seq_reg == SEQ_BURST) ? fastHalf : slowHalf;
    wire [7:0]          cntInc   = pulseCnt_reg + 8'h01;
    wire                lastPls  = (cntInc >= target);

    always_comb
    begin
        seq_next      = seq_reg;
        timer_next    = timerEnd ? timer_reg : timer_reg - 1'b1;
        pulseCnt_next = pulseCnt_reg;
        blinkOn_next  = blinkOn_reg;
        if (emcFault && (seq_reg != SEQ_EMC))
        begin
            seq_next     = SEQ_EMC;
            timer_next   = fastHalf;
            blinkOn_next = 1'b1;
        end
        else
        begin
            case (seq_reg)
                SEQ_IDLE:
                begin
                    blinkOn_next = 1'b0;
                    if (showErr)
                    begin
                        seq_next      = SEQ_BURST;
                        timer_next    = fastHalf;
                        pulseCnt_next = '0;
                        blinkOn_next  = 1'b1;
                    end
                end
                SEQ_EMC:
                begin
                    if (!emcFault)
                    begin
                        seq_next     = SEQ_GAP;
                        timer_next   = pauseLen;
                        blinkOn_next = 1'b0;
                    end
                    else if (timerEnd)
                    begin
                        timer_next   = fastHalf;
                        blinkOn_next = !blinkOn_reg;
                    end
                end
                SEQ_BURST, SEQ_CODE, SEQ_ARG:
                begin
                    if (!errActive_reg)
                    begin
                        seq_next     = SEQ_IDLE;
                        blinkOn_next = 1'b0;
                    end
                    else if (timerEnd && blinkOn_reg)
                    begin
                        blinkOn_next = 1'b0;
                        timer_next   = halfLen;
                    end
                    else if (timerEnd)
                    begin
                        pulseCnt_next = cntInc;
                        timer_next    = halfLen;
                        blinkOn_next  = 1'b1;
                        if (lastPls)
                        begin
                            pulseCnt_next = '0;
                            blinkOn_next  = 1'b0;
                            timer_next    = pauseLen;
                            seq_next      = (seq_reg == SEQ_BURST) ? SEQ_CODE :
                                            (seq_reg == SEQ_CODE)  ? SEQ_PAUSE :
                                                                     SEQ_GAP;
                            if (seq_reg == SEQ_BURST)
                            begin
                                timer_next   = slowHalf;
                                blinkOn_next = (errCode_reg != 4'h0);
                            end
                        end
                    end
                end
                SEQ_PAUSE:
                begin
                    blinkOn_next = 1'b0;
                    if (timerEnd)
                    begin
                        // A zero argument gives no pulses at all
                        seq_next      = SEQ_ARG;
                        pulseCnt_next = '0;
                        timer_next    = slowHalf;
                        blinkOn_next  = (errArg_reg != 8'h00) && errActive_reg;
                        if (errArg_reg == 8'h00)
                        begin
                            seq_next   = SEQ_GAP;
                            timer_next = pauseLen;
                        end
                    end
                end
                SEQ_GAP:
                begin
                    blinkOn_next = 1'b0;
                    if (timerEnd)
                    begin
                        // Repeat while the error persists
                        seq_next      = showErr ? SEQ_BURST : SEQ_IDLE;
                        timer_next    = fastHalf;
                        pulseCnt_next = '0;
                        blinkOn_next  = showErr;
                    end
                end
                default:
                begin
                    seq_next     = SEQ_IDLE;
                    blinkOn_next = 1'b0;
                end
            endcase
        end
    end

    // A zero code in the code phase would never count; treat one empty
    // off-half as the phase end by the same lastPls compare (target 0).
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            seq_reg      <= SEQ_IDLE;
            timer_reg    <= '0;
            pulseCnt_reg <= '0;
            blinkOn_reg  <= 1'b0;
        end
        else
        begin
            seq_reg      <= seq_next;
            timer_reg    <= timer_next;
            pulseCnt_reg <= pulseCnt_next;
            blinkOn_reg  <= blinkOn_next;
        end
    end

    // ------------------------------------------------------------
    // Lamp drivers
    // ------------------------------------------------------------
    tbdbs_mode_e runMode;
    logic [2:0]  rgbNext;

    assign runMode = tbdbs_mode_e'(ctrl_reg[CTRL_MODE_HI:CTRL_MODE_LO]);

    always_comb
    begin
        case (runMode)
            MODE_RUN:    rgbNext = RGB_GREEN;
            MODE_STOP:   rgbNext = RGB_RED;
            MODE_CONFIG: rgbNext = RGB_BLUE;
            MODE_FAULT:  rgbNext = RGB_YELLOW;
            default:     rgbNext = RGB_RED;
        endcase
    end

    wire startupNext = !ctrl_reg[CTRL_BOOT_DONE] || ctrl_reg[CTRL_SW_ERR];
    wire runNext     = fieldbusOk && !errActive_reg && !emcFault && !rstBusy;
    wire errLampNext = (pulseSeq || (seq_reg == SEQ_EMC)) && blinkOn_reg;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            runtimeStatusLampRgb <= RGB_RED;
            startupErrLamp       <= 1'b1;
            userDiagLamp         <= 1'b0;
            termRunLamp          <= 1'b0;
            termErrLamp          <= 1'b0;
        end
        else
        begin
            runtimeStatusLampRgb <= rgbNext;
            startupErrLamp       <= startupNext;
            userDiagLamp         <= ctrl_reg[CTRL_SW_USER];
            termRunLamp          <= runNext;
            termErrLamp          <= errLampNext;
        end
    end

endmodule : tbdbs_diag_blink

// ==== testbench/tbdbs_diag_blink_properties.sv ====
/*
 * Concurrent checks on the ports of the diagnostic lamp block.
 * Assumes one clock and synchronous reset.
 */
`timescale 1ns/1ps

module tbdbs_diag_blink_properties
    import tbdbs_pkg::*;
#(
    parameter int FAST_CYC = 2
)(
    // Clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // Register port
    input wire logic [7:0]  regAddr,
    input wire logic [31:0] regWrData,
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [31:0] regRdData,
    // Terminal bus side
    input wire logic        busErrSet,
    input wire logic        emcFault,
    input wire logic        fieldbusOk,
    input wire logic        cfgChanged,
    input wire logic        lenMismatch,
    input wire logic        inputsInvalid,
    input wire logic        inUpdBusy,
    input wire logic        outUpdBusy,
    input wire logic        watchdogHit,
    input wire logic        busResetPulse,
    // Lamps
    input wire logic [2:0]  runtimeStatusLampRgb,
    input wire logic        startupErrLamp,
    input wire logic        userDiagLamp,
    input wire logic        termRunLamp,
    input wire logic        termErrLamp
);
    wire       ctrlWr   = regWrEn && regAddr == ADDR_CTRL;
    wire       devRstWr = ctrlWr && regWrData[CTRL_DEV_RESET];
    wire       statRd   = regRdEn && regAddr == ADDR_STATUS;
    wire [5:0] lvl      = {watchdogHit, outUpdBusy, inUpdBusy, inputsInvalid, lenMismatch,
                           cfgChanged};
    logic      errSeen;

    default clocking dflt_cb @(posedge clk);
    endclocking
    default disable iff (rst);

    function automatic logic [2:0] colour(input logic [1:0] m);
        return (m == 2'd0) ? RGB_RED : (m == 2'd1) ? RGB_GREEN : (m == 2'd2) ? RGB_BLUE
                                                                               : RGB_YELLOW;
    endfunction : colour

    // Any error report or disturbance seen since reset
    always_ff @(posedge clk)
    begin
        if (rst)
            errSeen <= 1'b0;
        else if (busErrSet || emcFault)
            errSeen <= 1'b1;
    end

    a_reset_state:
    assert property ($fell(rst) |-> runtimeStatusLampRgb == RGB_RED && startupErrLamp
        && !userDiagLamp && !termRunLamp && !termErrLamp) else $error("lamps wrong after reset");
    a_dark_idle:
    assert property (!errSeen |-> !termErrLamp) else $error("error lamp lit without error");
    a_burst_start:
    assert property ((FAST_CYC == 2) && busErrSet && !errSeen && !emcFault |->
        ##3 termErrLamp[*3] ##1 !termErrLamp[*3] ##1 termErrLamp)
        else $error("first burst pulse malformed");
    a_status_map:
    assert property ($stable(lvl)[*3] ##0 statRd |=>
        {regRdData[31:16], regRdData[11:8], regRdData[2:1]} == {16'h0000, $past(lvl)})
        else $error("status bits misplaced");
    a_read_idle:
    assert property (!regRdEn |=> regRdData == 32'h0) else $error("read data outside read slot");
    a_reset_pulse:
    assert property (busResetPulse == $past(devRstWr)) else $error("bus reset pulse wrong");
    a_devrst_dark:
    assert property (devRstWr && !busErrSet && !emcFault |-> ##3 !termErrLamp[*4])
        else $error("error lamp survives device reset");
    a_run_dark:
    assert property (!fieldbusOk || emcFault |=> !termRunLamp) else $error("run lamp lit while faulty");
    a_mode_colour:
    assert property (ctrlWr ##1 !ctrlWr |=>
        runtimeStatusLampRgb == colour($past(regWrData[1:0], 2)))
        else $error("runtime lamp colour wrong");
    a_sw_lamps:
    assert property (ctrlWr ##1 !ctrlWr |=>
        userDiagLamp == $past(regWrData[CTRL_SW_USER], 2) && startupErrLamp ==
        (!$past(regWrData[CTRL_BOOT_DONE], 2) || $past(regWrData[CTRL_SW_ERR], 2)))
        else $error("software lamps wrong");
endmodule : tbdbs_diag_blink_properties

bind tbdbs_diag_blink tbdbs_diag_blink_properties #(.FAST_CYC(FAST_CYC)) chk_u (.*);

// ==== testbench/tbdbs_term_model.sv ====
/*
 * Behavioural model of the terminals on the terminal bus.
 * Assumes its tasks are called right after a rising clock edge.
 */
`timescale 1ns/1ps

module tbdbs_term_model (
    // Clock and bus reset from the block
    input  wire logic       clk,
    input  wire logic       busResetPulse,
    // Error report
    output logic            busErrSet = 1'b0,
    output logic [3:0]      busErrCode = 4'h0,
    output logic [7:0]      busErrArg = 8'h00,
    output logic            busErrLatch = 1'b0,
    output logic            busErrGone = 1'b0,
    output logic            emcFault = 1'b0,
    // Levels: fieldbus ok, watchdog, out busy, in busy, invalid, length, config
    output logic [6:0]      levels = 7'h00,
    // Bus resets seen
    output int              resetsSeen = 0
);
    always @(posedge clk)
    begin
        if (busResetPulse === 1'b1)
            resetsSeen <= resetsSeen + 1;
    end

    // Position counts active terminals only; released fields show the inverse
    // Reports come far apart, as from a slow polling task
    task automatic report(input logic [3:0] code, input logic [7:0] pos, input logic hold);
        busErrSet   <= 1'b1;
        busErrCode  <= code;
        busErrArg   <= pos;
        busErrLatch <= hold;
        @(posedge clk);
        busErrSet   <= 1'b0;
        busErrCode  <= ~code;
        busErrArg   <= ~pos;
        busErrLatch <= ~hold;
    endtask : report
endmodule : tbdbs_term_model

// ==== testbench/terminal_bus_diag_blink_status_test.sv ====
/*
 * Self-checking bench for the diagnostic lamp block.
 * Assumes the terminal model beside it and the checker bound to the block.
 */
`timescale 1ns/1ps

module terminal_bus_diag_blink_status_test
    import tbdbs_pkg::*;
;
    typedef struct {logic [3:0] code; logic [7:0] arg; logic hold;} tbdbs_row_s;
    tbdbs_row_s  rows [8] = '{'{4'h3, 8'h00, 1'b0}, '{4'h4, 8'h00, 1'b0},
                              '{4'h4, 8'h05, 1'b0}, '{4'h5, 8'h02, 1'b0},
                              '{4'h6, 8'h00, 1'b0}, '{4'h6, 8'h01, 1'b1},
                              '{4'h6, 8'h08, 1'b1}, '{4'h7, 8'h00, 1'b0}};
    logic [2:0]  colours [4] = '{RGB_RED, RGB_GREEN, RGB_BLUE, RGB_YELLOW};
    int          pos [6] = '{1, 2, 8, 9, 10, 11};
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [7:0]  regAddr = 8'h00;
    logic [31:0] regWrData = 32'h0;
    logic        regWrEn = 1'b0;
    logic        regRdEn = 1'b0;
    logic [31:0] regRdData, rdVal;
    logic        busErrSet, busErrLatch, busErrGone, emcFault, busResetPulse;
    logic [3:0]  busErrCode;
    logic [7:0]  busErrArg;
    logic [6:0]  levels;
    logic [2:0]  rgb;
    logic        startupErrLamp, userDiagLamp, termRunLamp, termErrLamp;
    int          resetsSeen, code, arg, burst, i, r, rises, runLen, maxRun;
    int          err_total = 0;
    int          checks_done = 0;
    int          nRst = 0;

    always #5 clk = ~clk;

    tbdbs_diag_blink #(.FAST_CYC(2), .SLOW_CYC(4), .PAUSE_LEN(6)) dut_u (
        .*, .fieldbusOk(levels[6]), .cfgChanged(levels[0]), .lenMismatch(levels[1]),
        .inputsInvalid(levels[2]), .inUpdBusy(levels[3]), .outUpdBusy(levels[4]),
        .watchdogHit(levels[5]), .runtimeStatusLampRgb(rgb));

    tbdbs_term_model term_u (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        checks_done++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH t=%0t %s", $time, msg);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        regAddr   <= a;
        regWrData <= d;
        regWrEn   <= 1'b1;
        @(posedge clk);
        regWrEn   <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        regAddr <= a;
        regRdEn <= 1'b1;
        @(posedge clk);
        regRdEn <= 1'b0;
        #1;
        d = regRdData;
        @(posedge clk);
    endtask : rd

    // Counts burst, code and argument pulses; ends on the next burst
    task automatic decode(output int nCode, output int nArg, output int nFast);
        int hi = 0;
        int lo = 0;
        int gapLen = 0;
        nCode = 0;
        nArg = 0;
        nFast = 0;
        for (int c = 0; c < 1500; c++)
        begin
            @(posedge clk);
            #1;
            if (termErrLamp === 1'b1)
            begin
                if (hi == 0)
                    gapLen = lo;
                hi++;
                lo = 0;
            end
            else
            begin
                if (hi > 3 && nCode > 0 && (nArg > 0 || gapLen > 5))
                    nArg++;
                else if (hi > 3)
                    nCode++;
                else if (hi > 0 && nCode > 0)
                    return;
                else if (hi > 0)
                    nFast++;
                hi = 0;
                lo++;
            end
        end
    endtask : decode

    task automatic conclude();
        if (err_total == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : conclude

    initial
    begin
        repeat (40000) @(posedge clk);
        err_total++;
        conclude();
    end

    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        term_u.levels <= 7'h40;
        @(posedge clk);
        #1;
        chk(startupErrLamp, 1'b1, "startup lamp dark before boot");
        for (r = 0; r < 8; r++)
        begin
            term_u.report(rows[r].code, rows[r].arg, rows[r].hold);
            decode(code, arg, burst);
            chk(burst, 8, "burst length");
            chk(code, rows[r].code, "code pulses");
            chk(arg, rows[r].arg, "argument pulses");
            chk(termRunLamp, 1'b0, "run lamp lit with error");
            decode(code, arg, burst);
            chk(arg, rows[r].arg, "sequence not repeated");
            term_u.busErrGone <= 1'b1;
            repeat (3) @(posedge clk);
            rd(ADDR_STATUS, rdVal);
            chk(rdVal, {31'h0, rows[r].hold}, "error flag after cause gone");
            if (rows[r].hold)
            begin
                nRst++;
                wr(ADDR_CTRL, 32'h111);
                @(posedge clk);
                rd(ADDR_STATUS, rdVal);
                chk(rdVal, 32'h8000, "status during bus reset");
                chk(resetsSeen, nRst, "bus reset count");
            end
            term_u.busErrGone <= 1'b0;
            repeat (110) @(posedge clk);
            rd(ADDR_STATUS, rdVal);
            chk(rdVal, 32'h0, "status not clean");
        end
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_CTRL, 32'h10 | i);
            @(posedge clk);
            #1;
            chk(rgb, colours[i], "runtime lamp colour");
        end
        wr(ADDR_CTRL, 32'h60);
        @(posedge clk);
        #1;
        chk({startupErrLamp, userDiagLamp}, 2'b11, "software lamps");
        wr(ADDR_CTRL, 32'h10);
        @(posedge clk);
        #1;
        chk({startupErrLamp, userDiagLamp}, 2'b00, "lamps after boot");
        for (i = 0; i < 6; i++)
        begin
            term_u.levels <= 7'h40 | (7'h01 << i);
            repeat (3) @(posedge clk);
            rd(ADDR_STATUS, rdVal);
            chk(rdVal, 32'h1 << pos[i], "status bit position");
        end
        term_u.levels <= 7'h40;
        repeat (3) @(posedge clk);
        #1;
        chk(termRunLamp, 1'b1, "run lamp dark when healthy");
        term_u.levels <= 7'h00;
        term_u.emcFault <= 1'b1;
        rises = 0;
        runLen = 0;
        maxRun = 0;
        for (i = 0; i < 60; i++)
        begin
            @(posedge clk);
            #1;
            rises += (termErrLamp === 1'b1 && runLen == 0);
            runLen = (termErrLamp === 1'b1) ? runLen + 1 : 0;
            maxRun = (runLen > maxRun) ? runLen : maxRun;
        end
        chk(rises >= 8 && maxRun == 3, 1'b1, "disturbance flashing");
        term_u.emcFault <= 1'b0;
        repeat (30) @(posedge clk);
        wr(ADDR_STATUS, 32'hFFFF);
        rd(8'hFC, rdVal);
        chk(rdVal, RD_UNMAPPED, "unmapped read");
        rd(ADDR_STATUS, rdVal);
        chk(rdVal, 32'h0, "status took a write");
        wr(ADDR_CTRL, 32'h41);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk({rgb, startupErrLamp, userDiagLamp, termRunLamp, termErrLamp},
            {RGB_RED, 4'b1000}, "state after reset");
        conclude();
    end
endmodule : terminal_bus_diag_blink_status_test
